// ===== spi_eeprom_consts.svh
/*
   Timing counts, opcodes and reset values for the serial EEPROM command master.
   Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef SPI_EEPROM_CONSTS_SVH
`define SPI_EEPROM_CONSTS_SVH

// ----------------------------------------------------------------------------
// One-byte instruction codes, sent most significant bit first
// ----------------------------------------------------------------------------
`define OP_WRITE_ENABLE  8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_STATUS_READ   8'h05
`define OP_STATUS_WRITE  8'h01
`define OP_ARRAY_READ    8'h03
`define OP_ARRAY_WRITE   8'h02

// ----------------------------------------------------------------------------
// Link timing and idle values
// ----------------------------------------------------------------------------
`define HALF_MIN         8'h03
`define DUMMY_BYTE       8'hFF
`define LINE_IDLE        1'b1
`define CS_DESELECT      1'b1

`endif

// ===== spi_eeprom_pkg.sv
/*
   Shared types: command kinds and sequencer states.
   Assumes nothing of its surroundings.
*/
package spi_eeprom_pkg;

   // -------------------------------------------------------------------------
   // Commands the master can run
   // -------------------------------------------------------------------------
   typedef enum logic [2:0] {
      write_enable_cmd  = 3'h0,
      write_disable_cmd = 3'h1,
      status_read_cmd   = 3'h2,
      status_write_cmd  = 3'h3,
      array_read_cmd    = 3'h4,
      array_write_cmd   = 3'h5
   } cmd_kind_e;

   // -------------------------------------------------------------------------
   // Sequencer states, Gray along idle-setup-shift-hold
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      st_idle  = 2'b00,
      st_setup = 2'b01,
      st_shift = 2'b11,
      st_hold  = 2'b10
   } seq_state_e;

endpackage : spi_eeprom_pkg

// ===== shift_if.sv
/*
   Carrier between the command sequencer and the byte shift engine.
   Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface shift_if;
   logic       start;
   logic [7:0] half_div;
   logic [7:0] tx_byte;
   logic [7:0] rx_byte;
   logic       done;

   modport seq    (output start, half_div, tx_byte, input rx_byte, done);
   modport engine (input start, half_div, tx_byte, output rx_byte, done);
endinterface : shift_if

`default_nettype wire

// ===== spi_byte_shifter.sv
/*
   Byte shift engine: one byte per start, mode 3, most significant bit first.
   Assumes start only while idle and half_div of at least three cycles.
*/
`timescale 1ns/1ns
`default_nettype none
`include "spi_eeprom_consts.svh"

module spi_byte_shifter (
   // Clock and reset
   input  wire logic      clk_sys,
   input  wire logic      srst,
   // Sequencer side
   shift_if.engine        sh_if,
   // Link pins
   input  wire logic      serial_in,
   output logic           sclk,
   output logic           serial_out
);

   typedef struct packed {
      logic       sync1;
      logic       sync2;
      logic       sclk;
      logic       sout;
      logic       active;
      logic       low_half;
      logic       done;
      logic [2:0] bit_n;
      logic [7:0] cnt;
      logic [7:0] sh;
   } eng_s;

   eng_s s;
   eng_s next_s;

   // ------------------------------------------------------------------------
   // Bit timing: falling edge launches, rising edge samples
   // ------------------------------------------------------------------------
   always_comb begin
      next_s       = s;
      next_s.sync1 = serial_in;
      next_s.sync2 = s.sync1;
      next_s.done  = 1'b0;
      if (!s.active) begin
         next_s.sclk = `LINE_IDLE;
         next_s.sout = `LINE_IDLE;
         if (sh_if.start) begin
            next_s.active   = 1'b1;
            next_s.low_half = 1'b1;
            next_s.sclk     = 1'b0;
            next_s.sout     = sh_if.tx_byte[7];
            next_s.sh       = sh_if.tx_byte;
            next_s.cnt      = 8'h00;
            next_s.bit_n    = 3'h0;
         end
      end else if (s.cnt != sh_if.half_div - 8'h01) begin
         next_s.cnt = s.cnt + 8'h01;
      end else begin
         next_s.cnt = 8'h00;
         if (s.low_half) begin
            // Synchronised input is two cycles old, hence the three-cycle floor
            next_s.low_half = 1'b0;
            next_s.sclk     = 1'b1;
            next_s.sh       = {s.sh[6:0], s.sync2};
         end else if (s.bit_n == 3'h7) begin
            next_s.active = 1'b0;
            next_s.done   = 1'b1;
            next_s.sout   = `LINE_IDLE;
         end else begin
            next_s.low_half = 1'b1;
            next_s.sclk     = 1'b0;
            next_s.sout     = s.sh[7];
            next_s.bit_n    = s.bit_n + 3'h1;
         end
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s <= '{sclk: `LINE_IDLE, sout: `LINE_IDLE, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign sclk          = s.sclk;
   assign serial_out    = s.sout;
   assign sh_if.done    = s.done;
   assign sh_if.rx_byte = s.sh;

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   property p_idle_clock_high;
      @(posedge clk_sys) disable iff (srst)
      (!s.active && !$past(s.active)) |-> (sclk && serial_out);
   endproperty
   a_idle_clock_high: assert property (p_idle_clock_high)
      else $error("clock or data not high while engine idle");

   property p_msb_first;
      @(posedge clk_sys) disable iff (srst)
      (sh_if.start && !s.active) |=> (!sclk && serial_out == $past(sh_if.tx_byte[7]));
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("first bit launched is not the top bit");

endmodule : spi_byte_shifter

`default_nettype wire

// ===== spi_eeprom_command_master.sv
/*
   Serial EEPROM command master: frames one command per select, drives the
   select pin, and streams write data in and read data out by byte offset.
   Assumes the command, wait and rate inputs come from logic on clk_sys and
   stay steady while busy; serial_in is an asynchronous pin.
*/
`timescale 1ns/1ns
`default_nettype none
`include "spi_eeprom_consts.svh"

// Functional notes
// - The link runs in mode 3, clock idling high and data sampled on the rising second edge.
// - A programmable wait separates the select going low from the first falling clock edge.
// - A programmable wait separates the last rising clock edge from the select going high.
// - Each access is select low, wait, shift bytes, wait, select high.
// - Commands start with an opcode: write enable 06, write disable 04, status read 05.
// - Status write is 01, array read is 03, array write is 02.
// - The status byte is only reached through its own opcodes and is passed as a plain byte.
// - After reset and between operations the select is held high.
// - When enabled the input is left as input, outputs idle high, and the rate is applied.
// - When disabled no new command starts; one already running completes, then the clock and data outputs stay high.
// - The select is a plain output driven apart from the shifter, which makes its own clock.
// - The byte offset at the memory equals the byte offset in the local buffer.
// - The select holds its high value before its output enable turns on.
module spi_eeprom_command_master #(
   parameter int ADDR_BYTES = 2
) (
   // Clock and reset
   input  wire logic                          clk_sys,
   input  wire logic                          srst,
   // Control
   input  wire logic                          serial_en,
   input  wire logic [7:0]                    half_div,
   input  wire logic [7:0]                    setup_cycles,
   input  wire logic [7:0]                    hold_cycles,
   // Command request
   input  wire logic                          cmd_valid,
   input  wire spi_eeprom_pkg::cmd_kind_e     cmd_kind,
   input  wire logic [8*ADDR_BYTES-1:0]       cmd_addr,
   input  wire logic [15:0]                   cmd_len,
   output logic                               cmd_ready,
   output logic                               busy,
   output logic                               done,
   // Write data stream
   input  wire logic                          tx_valid,
   input  wire logic [7:0]                    tx_data,
   output logic                               tx_ready,
   output logic [8*ADDR_BYTES-1:0]            tx_index,
   // Read data stream
   output logic                               rx_valid,
   output logic [7:0]                         rx_data,
   output logic [8*ADDR_BYTES-1:0]            rx_index,
   // Link pins
   output logic                               cs_n,
   output logic                               cs_oe,
   output logic                               sclk,
   output logic                               serial_out,
   input  wire logic                          serial_in
);

   localparam int AW = 8 * ADDR_BYTES;

   typedef struct packed {
      spi_eeprom_pkg::seq_state_e st;
      spi_eeprom_pkg::cmd_kind_e  kind;
      logic                       cs_n;
      logic                       cs_oe;
      logic                       cmd_ready;
      logic                       busy;
      logic                       done;
      logic                       inflight;
      logic                       start;
      logic                       tx_ready;
      logic                       rx_valid;
      logic [AW-1:0]              addr;
      logic [16:0]                idx;
      logic [16:0]                total;
      logic [7:0]                 cnt;
      logic [7:0]                 half;
      logic [7:0]                 tx_byte;
      logic [7:0]                 rx_data;
      logic [AW-1:0]              tx_index;
      logic [AW-1:0]              rx_index;
   } seq_s;

   seq_s s;
   seq_s next_s;

   shift_if sh_if ();

   // ------------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------------
   function automatic logic [7:0] op_code(input spi_eeprom_pkg::cmd_kind_e k);
      unique case (k)
         spi_eeprom_pkg::write_enable_cmd:  op_code = `OP_WRITE_ENABLE;
         spi_eeprom_pkg::write_disable_cmd: op_code = `OP_WRITE_DISABLE;
         spi_eeprom_pkg::status_read_cmd:   op_code = `OP_STATUS_READ;
         spi_eeprom_pkg::status_write_cmd:  op_code = `OP_STATUS_WRITE;
         spi_eeprom_pkg::array_read_cmd:    op_code = `OP_ARRAY_READ;
         spi_eeprom_pkg::array_write_cmd:   op_code = `OP_ARRAY_WRITE;
         default:                           op_code = `OP_WRITE_DISABLE;
      endcase
   endfunction : op_code

   // Opcode plus address bytes for array commands
   function automatic logic [16:0] hdr_len(input spi_eeprom_pkg::cmd_kind_e k);
      if (k == spi_eeprom_pkg::array_read_cmd || k == spi_eeprom_pkg::array_write_cmd) begin
         hdr_len = 17'(1 + ADDR_BYTES);
      end else begin
         hdr_len = 17'h00001;
      end
   endfunction : hdr_len

   // A programmed zero still gives one cycle
   function automatic logic wait_over(input logic [7:0] cnt, input logic [7:0] lim);
      wait_over = (lim == 8'h00) || (cnt >= lim - 8'h01);
   endfunction : wait_over

   // ------------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------------
   always_comb begin
      logic [16:0] hdr;
      logic [16:0] ndata;
      logic [16:0] pos;
      logic [7:0]  byte_out;
      logic        need_tx;
      logic        is_read;
      hdr      = hdr_len(s.kind);
      ndata    = 17'h00000;
      pos      = s.idx - hdr;
      byte_out = `DUMMY_BYTE;
      need_tx  = 1'b0;
      is_read  = (s.kind == spi_eeprom_pkg::array_read_cmd) ||
                 (s.kind == spi_eeprom_pkg::status_read_cmd);
      next_s          = s;
      next_s.cs_oe    = 1'b1;
      next_s.done     = 1'b0;
      next_s.start    = 1'b0;
      next_s.tx_ready = 1'b0;
      next_s.rx_valid = 1'b0;
      unique case (s.st)
         spi_eeprom_pkg::st_idle: begin
            next_s.cs_n = `CS_DESELECT;
            if (s.cmd_ready && cmd_valid) begin
               unique case (cmd_kind)
                  spi_eeprom_pkg::status_write_cmd: ndata = 17'h00001;
                  spi_eeprom_pkg::status_read_cmd,
                  spi_eeprom_pkg::array_read_cmd,
                  spi_eeprom_pkg::array_write_cmd:  ndata = {1'b0, cmd_len};
                  default:                          ndata = 17'h00000;
               endcase
               next_s.kind  = cmd_kind;
               next_s.addr  = cmd_addr;
               next_s.total = hdr_len(cmd_kind) + ndata;
               next_s.half  = (half_div < `HALF_MIN) ? `HALF_MIN : half_div;
               next_s.cs_n  = 1'b0;
               next_s.busy  = 1'b1;
               next_s.cnt   = 8'h00;
               next_s.st    = spi_eeprom_pkg::st_setup;
            end
         end
         spi_eeprom_pkg::st_setup: begin
            if (wait_over(s.cnt, setup_cycles)) begin
               next_s.idx = 17'h00000;
               next_s.st  = spi_eeprom_pkg::st_shift;
            end else begin
               next_s.cnt = s.cnt + 8'h01;
            end
         end
         spi_eeprom_pkg::st_shift: begin
            if (!s.inflight) begin
               if (s.idx == 17'h00000) begin
                  byte_out = op_code(s.kind);
               end else if (s.idx < hdr) begin
                  byte_out = 8'(s.addr >> (8 * (hdr - s.idx - 17'h00001)));
               end else if (!is_read) begin
                  need_tx  = 1'b1;
                  byte_out = tx_data;
               end
               // Stall with the clock high until write data shows up
               if (!need_tx || tx_valid) begin
                  next_s.start    = 1'b1;
                  next_s.inflight = 1'b1;
                  next_s.tx_byte  = byte_out;
                  next_s.tx_ready = need_tx;
                  next_s.tx_index = s.addr + AW'(pos);
               end
            end else if (sh_if.done) begin
               next_s.inflight = 1'b0;
               if (is_read && s.idx >= hdr) begin
                  next_s.rx_valid = 1'b1;
                  next_s.rx_data  = sh_if.rx_byte;
                  next_s.rx_index = s.addr + AW'(pos);
               end
               if (s.idx == s.total - 17'h00001) begin
                  next_s.cnt = 8'h00;
                  next_s.st  = spi_eeprom_pkg::st_hold;
               end else begin
                  next_s.idx = s.idx + 17'h00001;
               end
            end
         end
         spi_eeprom_pkg::st_hold: begin
            if (wait_over(s.cnt, hold_cycles)) begin
               next_s.cs_n = `CS_DESELECT;
               next_s.busy = 1'b0;
               next_s.done = 1'b1;
               next_s.st   = spi_eeprom_pkg::st_idle;
            end else begin
               next_s.cnt = s.cnt + 8'h01;
            end
         end
         default: next_s.st = spi_eeprom_pkg::st_idle;
      endcase
      // Disabled link takes no new command; one already running completes
      next_s.cmd_ready = (next_s.st == spi_eeprom_pkg::st_idle) && !next_s.done &&
                         serial_en && s.cs_oe;
   end

   // Select preloads high while its enable is still off
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s <= '{st: spi_eeprom_pkg::st_idle, kind: spi_eeprom_pkg::write_disable_cmd,
                cs_n: `CS_DESELECT, default: '0};
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------------------
   // Shift engine and outputs
   // ------------------------------------------------------------------------
   assign sh_if.start    = s.start;
   assign sh_if.half_div = s.half;
   assign sh_if.tx_byte  = s.tx_byte;

   spi_byte_shifter u_shifter (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .sh_if      (sh_if),
      .serial_in  (serial_in),
      .sclk       (sclk),
      .serial_out (serial_out)
   );

   assign cs_n      = s.cs_n;
   assign cs_oe     = s.cs_oe;
   assign cmd_ready = s.cmd_ready;
   assign busy      = s.busy;
   assign done      = s.done;
   assign tx_ready  = s.tx_ready;
   assign tx_index  = s.tx_index;
   assign rx_valid  = s.rx_valid;
   assign rx_data   = s.rx_data;
   assign rx_index  = s.rx_index;

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   property p_idle_deselected;
      @(posedge clk_sys) disable iff (srst)
      (s.st == spi_eeprom_pkg::st_idle && !$past(s.st == spi_eeprom_pkg::st_setup)) |-> cs_n;
   endproperty
   a_idle_deselected: assert property (p_idle_deselected)
      else $error("select low while sequencer idle");

   property p_oe_after_preload;
      @(posedge clk_sys) disable iff (srst)
      $rose(cs_oe) |-> (cs_n && $past(cs_n));
   endproperty
   a_oe_after_preload: assert property (p_oe_after_preload)
      else $error("select enabled without high preload");

   property p_setup_gap;
      @(posedge clk_sys) disable iff (srst)
      $fell(cs_n) |-> sclk [*3];
   endproperty
   a_setup_gap: assert property (p_setup_gap)
      else $error("clock fell too soon after select");

   property p_hold_gap;
      @(posedge clk_sys) disable iff (srst)
      $rose(cs_n) |-> ($past(sclk, 1) && $past(sclk, 2) && $past(sclk, 3));
   endproperty
   a_hold_gap: assert property (p_hold_gap)
      else $error("select rose too soon after clock");

   property p_opcode_first;
      @(posedge clk_sys) disable iff (srst)
      (s.start && s.idx == 17'h00000) |-> (s.tx_byte == op_code(s.kind));
   endproperty
   a_opcode_first: assert property (p_opcode_first)
      else $error("first byte of frame is not the opcode");

   property p_shift_selected;
      @(posedge clk_sys) disable iff (srst)
      (!sclk || s.st == spi_eeprom_pkg::st_shift) |-> !cs_n;
   endproperty
   a_shift_selected: assert property (p_shift_selected)
      else $error("clock active while deselected");

   property p_disabled_quiet;
      @(posedge clk_sys) disable iff (srst)
      (!serial_en && s.st == spi_eeprom_pkg::st_idle) |=> (sclk && serial_out && !busy);
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet)
      else $error("link lines not idle high while disabled");

   property p_done_ends_frame;
      @(posedge clk_sys) disable iff (srst)
      done |-> (cs_n && !busy && $past(s.st == spi_eeprom_pkg::st_hold));
   endproperty
   a_done_ends_frame: assert property (p_done_ends_frame)
      else $error("done without frame close");

endmodule : spi_eeprom_command_master

`default_nettype wire

// ===== eeprom_model.sv
/*
   Behavioural serial EEPROM slave on the far side of the command master.
   Assumes a mode 3 clock that toggles only while selected.
*/
`timescale 1ns/1ns
`default_nettype none

module eeprom_model (
   // Link pins
   input  wire logic cs_n,
   input  wire logic sclk,
   input  wire logic serial_out,
   output logic      serial_in
);
   logic [7:0] sh;
   logic [7:0] resp;
   int         bits;
   int         nbytes;
   logic [7:0] got [0:15];

   // -------------------------------------------------------------------------
   // Frame capture and answer
   // -------------------------------------------------------------------------
   initial serial_in = 1'b1;
   // New select restarts byte counting
   always @(negedge cs_n) begin
      bits = 0;
      nbytes = 0;
      resp = 8'hA0;
   end
   // Answer bit goes out after the falling edge
   always @(negedge sclk) begin
      if (!cs_n) serial_in = resp[7 - bits % 8];
   end
   // Sample on the rising edge; answer byte counts up per frame byte
   always @(posedge sclk) begin
      if (!cs_n) begin
         sh = {sh[6:0], serial_out};
         bits++;
         if (bits % 8 == 0) begin
            got[nbytes % 16] = sh;
            nbytes++;
            resp = 8'hA0 + 8'(nbytes);
         end
      end
   end
   // Released line flips, so a stale bit cannot pass for data
   always @(posedge cs_n) serial_in = ~serial_in;
endmodule : eeprom_model

`default_nettype wire

// ===== tb_spi_eeprom_command_master.sv
/*
   Self-checking bench for the serial EEPROM command master.
   Assumes the design files and the slave model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_spi_eeprom_command_master;
   logic                      clk_sys, srst, serial_en, cmd_valid, tx_valid;
   logic [7:0]                half_div, setup_cycles, hold_cycles, tx_data, rx_data;
   spi_eeprom_pkg::cmd_kind_e cmd_kind;
   logic [15:0]               cmd_addr, cmd_len, tx_index, rx_index;
   logic                      cmd_ready, busy, done, tx_ready, rx_valid;
   logic                      cs_n, cs_oe, sclk, serial_out, serial_in;
   int                        errors, check_count, cyc, t_csf, t_sf, t_sr, t_csr, idle_bad, nrx;
   logic [7:0]                rxq [0:15];
   logic [15:0]               rxi [0:15];

   spi_eeprom_command_master #(.ADDR_BYTES(2)) spi_eeprom_command_master_i (
      .clk_sys(clk_sys), .srst(srst), .serial_en(serial_en), .half_div(half_div),
      .setup_cycles(setup_cycles), .hold_cycles(hold_cycles), .cmd_valid(cmd_valid),
      .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_ready(cmd_ready),
      .busy(busy), .done(done), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .tx_index(tx_index), .rx_valid(rx_valid), .rx_data(rx_data), .rx_index(rx_index),
      .cs_n(cs_n), .cs_oe(cs_oe), .sclk(sclk), .serial_out(serial_out), .serial_in(serial_in));
   eeprom_model eeprom_model_i (.cs_n(cs_n), .sclk(sclk), .serial_out(serial_out),
      .serial_in(serial_in));

   // -------------------------------------------------------------------------
   // Clock and link monitors
   // -------------------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Clock must sit high whenever the memory is deselected
   always @(posedge clk_sys) begin
      cyc++;
      if (!srst && cs_n === 1'b1 && sclk !== 1'b1) idle_bad++;
   end
   always @(negedge cs_n) begin
      t_csf = cyc;
      t_sf = -1;
   end
   always @(negedge sclk) begin
      if (t_sf < 0) t_sf = cyc;
   end
   always @(posedge sclk) t_sr = cyc;
   always @(posedge cs_n) t_csr = cyc;

   // -------------------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   // One framed command; write bytes are 30h upward, read bytes are queued
   task automatic do_cmd(input spi_eeprom_pkg::cmd_kind_e k, input logic [15:0] a,
                         input logic [15:0] n);
      int i;
      int tn;
      tn = 0;
      nrx = 0;
      cmd_kind = k;
      {cmd_addr, cmd_len, cmd_valid, tx_data, tx_valid} = {a, n, 1'b1, 8'h30, 1'b1};
      for (i = 0; i < 9000 && done !== 1'b1; i++) begin
         @(posedge clk_sys);
         #1;
         if (busy === 1'b1) cmd_valid = 1'b0;
         if (tx_ready === 1'b1) begin
            if (k == spi_eeprom_pkg::array_write_cmd) chk("tx_index", a + tn, tx_index);
            tn++;
            tx_data = 8'h30 + 8'(tn);
         end
         if (rx_valid === 1'b1) begin
            rxq[nrx % 16] = rx_data;
            rxi[nrx % 16] = rx_index;
            nrx++;
         end
      end
      {cmd_valid, tx_valid} = 2'b00;
      if (done !== 1'b1) begin
         errors++;
         $display("BAD done expected 1 seen %b", done);
         final_report();
      end
      chk("setup gap", 1, t_sf - t_csf >= setup_cycles + 2);
      chk("hold gap", 1, t_csr - t_sr >= half_div + hold_cycles);
      @(posedge clk_sys);
      #1;
   endtask : do_cmd

   // -------------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------------
   task automatic t_reset;
      chk("cs_n in reset", 1, cs_n);
      chk("cs_oe in reset", 0, cs_oe);
      chk("sclk and out idle", 2'b11, {sclk, serial_out});
      srst = 1'b0;
      @(posedge clk_sys);
      #1;
      chk("cs_n before enable", 1, cs_n);
      chk("cs_oe after release", 1, cs_oe);
      $display("test reset done");
   endtask : t_reset

   task automatic t_opcodes;
      logic [7:0] op [0:5] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h02};
      int         nb [0:5] = '{1, 1, 2, 2, 4, 4};
      for (int k = 0; k < 6; k++) begin
         do_cmd(spi_eeprom_pkg::cmd_kind_e'(k), 16'h1234, 16'h0001);
         chk("opcode", op[k], eeprom_model_i.got[0]);
         chk("frame bytes", nb[k], eeprom_model_i.nbytes);
      end
      $display("test opcodes done");
   endtask : t_opcodes

   task automatic t_array;
      do_cmd(spi_eeprom_pkg::array_write_cmd, 16'h01FE, 16'h0003);
      chk("address", 16'h01FE, {eeprom_model_i.got[1], eeprom_model_i.got[2]});
      for (int n = 0; n < 3; n++) chk("write byte", 8'h30 + n, eeprom_model_i.got[3 + n]);
      do_cmd(spi_eeprom_pkg::array_read_cmd, 16'h01FD, 16'h0003);
      chk("read count", 3, nrx);
      for (int n = 0; n < 3; n++) chk("read byte", 8'hA3 + n, rxq[n]);
      for (int n = 0; n < 3; n++) chk("rx_index", 16'h01FD + n, rxi[n]);
      $display("test array done");
   endtask : t_array

   task automatic t_status;
      do_cmd(spi_eeprom_pkg::status_read_cmd, 16'h0000, 16'h0002);
      chk("status byte", 16'hA1A2, {rxq[0], rxq[1]});
      chk("status index", 32'h00000001, {rxi[0], rxi[1]});
      do_cmd(spi_eeprom_pkg::status_write_cmd, 16'h0000, 16'h0009);
      chk("status write", 16'h0130, {eeprom_model_i.got[0], eeprom_model_i.got[1]});
      chk("status length", 2, eeprom_model_i.nbytes);
      $display("test status done");
   endtask : t_status

   // Long guard waits with the fastest allowed bit rate
   task automatic t_waits;
      {half_div, setup_cycles, hold_cycles} = {8'h03, 8'h14, 8'h0F};
      do_cmd(spi_eeprom_pkg::array_read_cmd, 16'hFFFF, 16'h0001);
      chk("fast read", 8'hA3, rxq[0]);
      {half_div, setup_cycles, hold_cycles} = {8'h08, 8'h02, 8'h03};
      $display("test waits done");
   endtask : t_waits

   // Disabled link refuses work and keeps every line high
   task automatic t_disable;
      int bad;
      bad = 0;
      // Ready is registered, so let it drop before asking
      serial_en = 1'b0;
      @(posedge clk_sys);
      #1;
      cmd_kind = spi_eeprom_pkg::write_enable_cmd;
      cmd_valid = 1'b1;
      repeat (60) begin
         @(posedge clk_sys);
         #1;
         if ({cs_n, sclk, serial_out, busy, cmd_ready} !== 5'b11100) bad++;
      end
      chk("disabled lines", 0, bad);
      {serial_en, cmd_valid} = 2'b10;
      $display("test disable done");
   endtask : t_disable

   // -------------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------------
   initial begin
      {srst, serial_en, cmd_valid, tx_valid, tx_data} = {3'b110, 1'b0, 8'h00};
      cmd_kind = spi_eeprom_pkg::write_enable_cmd;
      {cmd_addr, cmd_len} = 32'h0;
      {half_div, setup_cycles, hold_cycles} = {8'h08, 8'h02, 8'h03};
      {errors, check_count, cyc, idle_bad} = 128'h0;
      repeat (16) @(posedge clk_sys);
      #1;
      t_reset();
      t_opcodes();
      t_array();
      t_status();
      t_waits();
      t_disable();
      chk("clock idle high", 0, idle_bad);
      final_report();
   end
endmodule : tb_spi_eeprom_command_master

`default_nettype wire
